// ==== inc/ulc_pkg.sv ====
// Shared constants for the serial line control and status block.
// Assumes an 8-bit register port at offsets 0 to 7.
package ulc_pkg;
  // Register offsets
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_FIFO = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  // Line format control fields
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_SIL = 6;
  localparam int LCR_DLAB = 7;
  // Modem control fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_LBRI = 2;
  localparam int MCR_IRQEN = 3;
  localparam int MCR_LOOP = 4;
  // FIFO control fields
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  // Interrupt enable field
  localparam int IER_TX = 1;
  // Error bits above the data in a receive entry
  localparam int RXE_PE = 8;
  localparam int RXE_FE = 9;
  localparam int RXE_BI = 10;
  // Reset values
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [4:0] MCR_RST = 5'h00;
  localparam logic [3:0] IER_RST = 4'h0;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // Timing in 16x ticks
  localparam logic [5:0] TK_HALF = 6'h07;
  localparam logic [5:0] TK_BIT = 6'h0f;
  localparam logic [5:0] TK_STOP1 = 6'h0f;
  localparam logic [5:0] TK_STOP15 = 6'h17;
  localparam logic [5:0] TK_STOP2 = 6'h1f;
  localparam int FIFO_DEPTH = 16;
  // Character bit phases, shared by transmitter and receiver
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ulc_bit_e;
endpackage : ulc_pkg

// ==== design/ulc_fifo.sv ====
// Flip-flop FIFO with optional single-entry limit.
// Assumes the caller never pushes when full unless it also pops.
`timescale 1ns/10ps
module ulc_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic one_deep_in,
  input wire logic push_in,
  input wire logic [W-1:0] data_in,
  input wire logic pop_in,
  output logic [W-1:0] data_out,
  output logic empty_out,
  output logic full_out
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;

  // Head and fill level; one-deep mode acts as a holding register
  assign data_out = mem[rp];
  assign empty_out = (cnt == '0);
  assign full_out = one_deep_in ? !empty_out : (cnt == (AW+1)'(DEPTH));

  // Pointer arithmetic
  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (clear_in) begin
      next_wp = '0;
      next_rp = '0;
      next_cnt = '0;
    end else begin
      if (push_in) next_wp = wp + 1'b1;
      if (pop_in && !empty_out) next_rp = rp + 1'b1;
      next_cnt = cnt + (AW+1)'(push_in) - (AW+1)'(pop_in && !empty_out);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage has no reset; contents are meaningless until pushed
  always_ff @(posedge sys_clk_in) begin
    if (push_in && !clear_in) mem[wp] <= data_in;
  end
endmodule : ulc_fifo

// ==== design/ulc_uart.sv ====
// Serial port core: register file, baud divider, transmitter, receiver.
// Assumes a synchronous register port and pins already in the clock domain.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module ulc_uart #(
  parameter int DEPTH = ulc_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rd_data_out,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic dcd_n_in,
  output logic dtr_n_out,
  output logic rts_n_out,
  output logic irq_out
);
  logic [7:0] lcr, next_lcr, scr, next_scr;
  logic [4:0] mcr, next_mcr;
  logic [3:0] ier, next_ier;
  logic [15:0] div, next_div, bcnt, next_bcnt;
  logic fen, next_fen, tick;
  logic dlab, lb, wr_thr, pop_cpu, lsr_rd, rx_clr, tx_clr;
  logic [7:0] mask;
  logic [2:0] last;

  // Decoded controls
  assign dlab = lcr[ulc_pkg::LCR_DLAB];
  assign lb = mcr[ulc_pkg::MCR_LOOP];
  assign last = {1'b1, lcr[1:0]};
  assign mask = {lcr[1:0] == 2'h3, lcr[1], |lcr[1:0], 5'h1f};
  assign wr_thr = wr_in && addr_in == ulc_pkg::ADDR_DATA && !dlab;
  assign pop_cpu = rd_in && addr_in == ulc_pkg::ADDR_DATA && !dlab;
  assign lsr_rd = rd_in && addr_in == ulc_pkg::ADDR_LSR;
  // Toggling FIFO mode flushes both queues so no stale depth remains
  assign rx_clr = wr_in && addr_in == ulc_pkg::ADDR_FIFO
    && (wr_data_in[ulc_pkg::FCR_RXCLR] || wr_data_in[ulc_pkg::FCR_EN] != fen);
  assign tx_clr = wr_in && addr_in == ulc_pkg::ADDR_FIFO
    && (wr_data_in[ulc_pkg::FCR_TXCLR] || wr_data_in[ulc_pkg::FCR_EN] != fen);

  // Control register writes
  always_comb begin
    next_lcr = lcr;
    next_mcr = mcr;
    next_ier = ier;
    next_div = div;
    next_scr = scr;
    next_fen = fen;
    if (wr_in) begin
      unique case (addr_in)
        ulc_pkg::ADDR_DATA: if (dlab) next_div[7:0] = wr_data_in;
        ulc_pkg::ADDR_IER: begin
          if (dlab) next_div[15:8] = wr_data_in;
          else next_ier = wr_data_in[3:0];
        end
        ulc_pkg::ADDR_FIFO: next_fen = wr_data_in[ulc_pkg::FCR_EN];
        ulc_pkg::ADDR_LCR: next_lcr = wr_data_in;
        ulc_pkg::ADDR_MCR: next_mcr = wr_data_in[4:0];
        ulc_pkg::ADDR_SCR: next_scr = wr_data_in;
        default: next_scr = scr;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lcr <= ulc_pkg::LCR_RST;
      mcr <= ulc_pkg::MCR_RST;
      ier <= ulc_pkg::IER_RST;
      div <= ulc_pkg::DIV_RST;
      scr <= 8'h00;
      fen <= 1'b0;
    end else begin
      lcr <= next_lcr;
      mcr <= next_mcr;
      ier <= next_ier;
      div <= next_div;
      scr <= next_scr;
      fen <= next_fen;
    end
  end

  // 16x baud enable; a divisor of zero behaves as one
  // A count left above a newly lowered divisor restarts at once, not after it
  assign tick = (bcnt <= 16'h0001) || (bcnt > div);
  assign next_bcnt = tick ? div : bcnt - 16'h0001;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) bcnt <= ulc_pkg::DIV_RST;
    else bcnt <= next_bcnt;
  end

  // Transmit queue: depth one doubles as the holding register
  logic [7:0] tx_head;
  logic tx_empty, tx_full, tx_pop;
  ulc_fifo #(.W(8), .DEPTH(DEPTH), .AW($clog2(DEPTH))) u_txq (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(tx_clr),
    .one_deep_in(!fen),
    // A write may land in the cycle the shifter frees the slot
    .push_in(wr_thr && (!tx_full || tx_pop)),
    .data_in(wr_data_in),
    .pop_in(tx_pop),
    .data_out(tx_head),
    .empty_out(tx_empty),
    .full_out(tx_full)
  );

  ulc_pkg::ulc_bit_e tx_st, next_tx_st;
  logic [5:0] tx_cnt, next_tx_cnt, stop_end;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_sh, next_tx_sh;
  logic tx_line, next_tx_line, tx_par, next_tx_par, hold_empty, tx_idle;

  assign stop_end = !lcr[ulc_pkg::LCR_STOP] ? ulc_pkg::TK_STOP1
    : (lcr[1:0] == 2'h0 ? ulc_pkg::TK_STOP15 : ulc_pkg::TK_STOP2);
  assign hold_empty = tx_empty;
  // idle needs queue and shifter both empty
  assign tx_idle = tx_empty && tx_st == ulc_pkg::ST_IDLE;

  // parity value from data and format
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] l);
    if (l[ulc_pkg::LCR_STICK]) par_of = !l[ulc_pkg::LCR_EPS];
    else par_of = l[ulc_pkg::LCR_EPS] ? ^d : ~^d;
  endfunction : par_of

  // Transmit bit sequencer
  always_comb begin
    next_tx_st = tx_st;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_tx_line = tx_line;
    next_tx_par = tx_par;
    tx_pop = 1'b0;
    if (tx_st != ulc_pkg::ST_IDLE && tick) next_tx_cnt = tx_cnt + 6'h01;
    unique case (tx_st)
      ulc_pkg::ST_IDLE: begin
        next_tx_line = 1'b1;
        if (!tx_empty) begin
          tx_pop = 1'b1;
          next_tx_sh = tx_head & mask;
          next_tx_par = par_of(tx_head & mask, lcr);
          next_tx_line = 1'b0;
          next_tx_cnt = 6'h00;
          next_tx_st = ulc_pkg::ST_START;
        end
      end
      ulc_pkg::ST_START: if (tick && tx_cnt == ulc_pkg::TK_BIT) begin
        next_tx_line = tx_sh[0];
        next_tx_bit = 3'h0;
        next_tx_cnt = 6'h00;
        next_tx_st = ulc_pkg::ST_DATA;
      end
      ulc_pkg::ST_DATA: if (tick && tx_cnt == ulc_pkg::TK_BIT) begin
        next_tx_cnt = 6'h00;
        next_tx_sh = {1'b0, tx_sh[7:1]};
        next_tx_line = tx_sh[1];
        next_tx_bit = tx_bit + 3'h1;
        if (tx_bit == last) begin
          next_tx_st = lcr[ulc_pkg::LCR_PEN] ? ulc_pkg::ST_PAR : ulc_pkg::ST_STOP;
          next_tx_line = lcr[ulc_pkg::LCR_PEN] ? tx_par : 1'b1;
        end
      end
      ulc_pkg::ST_PAR: if (tick && tx_cnt == ulc_pkg::TK_BIT) begin
        next_tx_cnt = 6'h00;
        next_tx_line = 1'b1;
        next_tx_st = ulc_pkg::ST_STOP;
      end
      ulc_pkg::ST_STOP: if (tick && tx_cnt == stop_end) begin
        next_tx_st = ulc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st <= ulc_pkg::ST_IDLE;
      tx_cnt <= 6'h00;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      tx_line <= 1'b1;
      tx_par <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      tx_line <= next_tx_line;
      tx_par <= next_tx_par;
    end
  end

  // Receive side
  ulc_pkg::ulc_bit_e rx_st, next_rx_st;
  logic [5:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh, rx_data;
  logic rx_prev, next_rx_prev, rx_zero, next_rx_zero, rx_pe, next_rx_pe;
  logic rx_src, rx_push, rx_fe, rx_bi;
  assign rx_src = lb ? tx_line : serial_in;
  // Right-justify short words
  assign rx_data = rx_sh >> (3'h7 - last);
  assign rx_fe = !rx_src;
  assign rx_bi = rx_zero && !rx_src;

  // Receive bit sequencer, sampling mid-bit
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_zero = rx_zero;
    next_rx_pe = rx_pe;
    next_rx_prev = tick ? rx_src : rx_prev;
    rx_push = 1'b0;
    if (tick) next_rx_cnt = rx_cnt + 6'h01;
    unique case (rx_st)
      // Needs a high sample first, so a held break is one character
      ulc_pkg::ST_IDLE: if (tick && rx_prev && !rx_src) begin
        next_rx_cnt = 6'h00;
        next_rx_st = ulc_pkg::ST_START;
      end
      ulc_pkg::ST_START: if (tick && rx_cnt == ulc_pkg::TK_HALF) begin
        next_rx_cnt = 6'h00;
        next_rx_bit = 3'h0;
        next_rx_sh = 8'h00;
        next_rx_zero = 1'b1;
        next_rx_pe = 1'b0;
        next_rx_st = rx_src ? ulc_pkg::ST_IDLE : ulc_pkg::ST_DATA;
      end
      ulc_pkg::ST_DATA: if (tick && rx_cnt == ulc_pkg::TK_BIT) begin
        next_rx_cnt = 6'h00;
        // first data bit is bit zero
        next_rx_sh = {rx_src, rx_sh[7:1]};
        next_rx_zero = rx_zero && !rx_src;
        next_rx_bit = rx_bit + 3'h1;
        if (rx_bit == last)
          next_rx_st = lcr[ulc_pkg::LCR_PEN] ? ulc_pkg::ST_PAR : ulc_pkg::ST_STOP;
      end
      ulc_pkg::ST_PAR: if (tick && rx_cnt == ulc_pkg::TK_BIT) begin
        next_rx_cnt = 6'h00;
        next_rx_zero = rx_zero && !rx_src;
        next_rx_pe = rx_src != par_of(rx_data, lcr);
        next_rx_st = ulc_pkg::ST_STOP;
      end
      // Only the first stop bit is checked
      ulc_pkg::ST_STOP: if (tick && rx_cnt == ulc_pkg::TK_BIT) begin
        rx_push = 1'b1;
        next_rx_st = ulc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st <= ulc_pkg::ST_IDLE;
      rx_cnt <= 6'h00;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_zero <= 1'b0;
      rx_pe <= 1'b0;
      rx_prev <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_zero <= next_rx_zero;
      rx_pe <= next_rx_pe;
      rx_prev <= next_rx_prev;
    end
  end

  // Receive queue; a full holding register is overwritten by pop plus push
  logic [10:0] rx_head;
  logic rx_empty, rx_full, rx_ovr, rx_in_en, rx_pop;
  assign rx_ovr = rx_push && rx_full && !pop_cpu;
  assign rx_in_en = rx_push && (!rx_full || pop_cpu || !fen);
  assign rx_pop = pop_cpu || (rx_ovr && !fen);
  ulc_fifo #(.W(11), .DEPTH(DEPTH), .AW($clog2(DEPTH))) u_rxq (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(rx_clr),
    .one_deep_in(!fen),
    .push_in(rx_in_en),
    .data_in({rx_bi, rx_fe, rx_pe && !rx_bi, rx_bi ? 8'h00 : rx_data}),
    .pop_in(rx_pop),
    .data_out(rx_head),
    .empty_out(rx_empty),
    .full_out(rx_full)
  );

  // Status flags; a new event beats a same-cycle status read
  logic [2:0] err, next_err;
  logic [4:0] ecnt, next_ecnt;
  logic seen, next_seen, overrun_error, next_oer, rx_fifo_error_flag, next_rx_fifo_error_flag, push_err, head_err;
  assign push_err = rx_in_en && (rx_bi || rx_fe || rx_pe);
  assign head_err = rx_pop && !rx_empty && |rx_head[10:8];

  always_comb begin
    // errors of the head entry, once per entry
    next_err = err & {3{!lsr_rd}};
    if (!rx_empty && !seen) next_err = next_err | rx_head[10:8];
    next_seen = rx_pop ? 1'b0 : (seen || !rx_empty);
    next_oer = (overrun_error && !lsr_rd) || rx_ovr;
    next_ecnt = rx_clr ? 5'h00 : ecnt + 5'(push_err) - 5'(head_err);
    next_rx_fifo_error_flag = fen && (next_ecnt != 5'h00 || (rx_fifo_error_flag && !lsr_rd));
    if (rx_clr) begin
      next_err = 3'h0;
      next_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err <= 3'h0;
      ecnt <= 5'h00;
      seen <= 1'b0;
      overrun_error <= 1'b0;
      rx_fifo_error_flag <= 1'b0;
    end else begin
      err <= next_err;
      ecnt <= next_ecnt;
      seen <= next_seen;
      overrun_error <= next_oer;
      rx_fifo_error_flag <= next_rx_fifo_error_flag;
    end
  end

  // Read path and pin drivers, all registered
  logic [7:0] lsr, msr, next_rd;
  logic [3:0] mdm;
  logic next_serial_out, next_dtr, next_rts, next_irq, irq_cond;
  assign irq_cond = ier[ulc_pkg::IER_TX] && hold_empty;
  assign lsr = {rx_fifo_error_flag, tx_idle, hold_empty, err, overrun_error, !rx_empty};
  assign mdm = lb ? {mcr[ulc_pkg::MCR_IRQEN], mcr[ulc_pkg::MCR_LBRI],
                     mcr[ulc_pkg::MCR_DTR], mcr[ulc_pkg::MCR_RTS]}
                  : ~{dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
  assign msr = {mdm, 4'h0};

  always_comb begin
    next_rd = rd_data_out;
    if (rd_in) begin
      unique case (addr_in)
        ulc_pkg::ADDR_DATA: next_rd = dlab ? div[7:0] : rx_head[7:0];
        ulc_pkg::ADDR_IER: next_rd = dlab ? div[15:8] : {4'h0, ier};
        ulc_pkg::ADDR_FIFO: next_rd = {fen, fen, 4'h0, irq_cond, !irq_cond};
        ulc_pkg::ADDR_LCR: next_rd = lcr;
        ulc_pkg::ADDR_MCR: next_rd = {3'h0, mcr};
        ulc_pkg::ADDR_LSR: next_rd = lsr;
        ulc_pkg::ADDR_MSR: next_rd = msr;
        ulc_pkg::ADDR_SCR: next_rd = scr;
        default: next_rd = 8'h00;
      endcase
    end
    // output high in loopback, otherwise the transmit line bit, held low when silenced
    next_serial_out = lb ? 1'b1 : (tx_line && !lcr[ulc_pkg::LCR_SIL]);
    // inverted control bits, inactive in loopback
    next_dtr = lb || !mcr[ulc_pkg::MCR_DTR];
    next_rts = lb || !mcr[ulc_pkg::MCR_RTS];
    next_irq = irq_cond && mcr[ulc_pkg::MCR_IRQEN];
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
      serial_out <= 1'b1;
      dtr_n_out <= 1'b1;
      rts_n_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      rd_data_out <= next_rd;
      serial_out <= next_serial_out;
      dtr_n_out <= next_dtr;
      rts_n_out <= next_rts;
      irq_out <= next_irq;
    end
  end

  // Checks on the registered outputs and flags
  loop_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    lb |=> serial_out) else $error("serial output not high in loopback");
  modem_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    lb |=> dtr_n_out && rts_n_out) else $error("modem outputs active in loopback");
  dtr_inv_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !lb |=> dtr_n_out == !$past(mcr[ulc_pkg::MCR_DTR]))
    else $error("dtr output not inverted control bit");
  div_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_in && dlab && addr_in == ulc_pkg::ADDR_DATA |=> div[7:0] == $past(wr_data_in))
    else $error("divisor low byte not written");
  hold_clr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_thr && !tx_clr |=> !hold_empty) else $error("holding empty after data write");
  idle_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    lsr_rd |=> rd_data_out[6] == ($past(tx_empty) && $past(tx_st) == ulc_pkg::ST_IDLE))
    else $error("transmitter idle flag wrong");
  rx_fifo_error_flag_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    lsr_rd && !fen |=> !rd_data_out[7]) else $error("fifo error flag set outside fifo mode");
  ready_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    lsr_rd |=> rd_data_out[0] == !$past(rx_empty)) else $error("ready flag wrong");
  par_bit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tx_st == ulc_pkg::ST_START && lcr[ulc_pkg::LCR_PEN] && !lcr[ulc_pkg::LCR_STICK]
    |-> ((^tx_sh) ^ tx_par) == !lcr[ulc_pkg::LCR_EPS])
    else $error("parity bit gives wrong count of ones");
endmodule : ulc_uart

// ==== verification/ulc_remote.sv ====
// Remote serial port model: sends characters, decodes what it hears.
// Assumes divisor 1, so one bit lasts 16 clocks; line idles high.
`timescale 1ns/10ps
module ulc_remote (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic [3:0] nbits_in,
  input wire logic par_en_in,
  output logic line_out,
  output logic got_out,
  output logic [8:0] got_data_out
);
  logic [8:0] w;
  // Idle line before any traffic
  initial begin
    line_out = 1'b1;
    got_out = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold
  // start, data lsb first, parity, stop
  task automatic send(input logic [7:0] d, input int n, input logic pe, input logic p,
                      input logic st, input int sn);
    line_out <= 1'b0;
    hold(16);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      hold(16);
    end
    if (pe) begin
      line_out <= p;
      hold(16);
    end
    line_out <= st;
    hold(sn);
    line_out <= 1'b1;
    hold(20);
  endtask : send
  // Decoder samples mid-bit, parity lands in bit 8
  always begin
    @(negedge line_in);
    hold(8);
    w = 9'h000;
    for (int i = 0; i < nbits_in; i++) begin
      hold(16);
      w[i] = line_in;
    end
    if (par_en_in) begin
      hold(16);
      w[8] = line_in;
    end
    hold(16);
    got_data_out <= w;
    got_out <= 1'b1;
    hold(1);
    got_out <= 1'b0;
  end
endmodule : ulc_remote

// ==== verification/ulc_uart_tb.sv ====
// Self-checking bench for the serial port core.
// Assumes the remote model on the serial pins and reset divisor 1.
`timescale 1ns/10ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, g, x); end end
module ulc_uart_tb;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rd_pend = 1'b0, lb = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdat, d, lcr;
  logic [3:0] modem = 4'hf, nbits = 4'h8;
  logic pen = 1'b0, p, so, si, dtr_n, rts_n, irq, got;
  logic [8:0] gd, t;
  logic [15:0] e;
  logic [15:0] rq[$];
  logic [8:0] tq[$];
  int error_cnt = 0, total_checks = 0, seed = 6490, gots = 0;
  ulc_uart uut (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdat), .serial_in(si), .serial_out(so),
    .cts_n_in(modem[0]), .dsr_n_in(modem[1]), .ri_n_in(modem[2]), .dcd_n_in(modem[3]),
    .dtr_n_out(dtr_n), .rts_n_out(rts_n), .irq_out(irq));
  ulc_remote remote (.clk_in(clk), .line_in(so), .nbits_in(nbits), .par_en_in(pen),
    .line_out(si), .got_out(got), .got_data_out(gd));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Read notes {mask, value}; the monitor compares a cycle later
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
    rq.push_back({m, v});
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic wait_tx(input int n);
    for (int k = 0; k < 2000 && gots < n; k++) @(posedge clk);
    `CHK(gots, n)
  endtask : wait_tx
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // Monitor: oldest note against each read and each decoded character
  always @(posedge clk) begin
    if (rd_pend) begin
      e = rq.pop_front();
      `CHK(rdat & e[15:8], e[7:0])
    end
    if (got) begin
      gots++;
      t = tq.pop_front();
      `CHK(gd, t)
    end
    if (lb) `CHK(so, 1'b1)
    rd_pend <= rd_s;
  end
  // Watchdog, far beyond the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ulc_pkg::ADDR_LCR, 8'hff, 8'h03);
    rd(ulc_pkg::ADDR_LSR, 8'hff, 8'h60);
    // divisor behind offsets 0 and 1
    wr(ulc_pkg::ADDR_LCR, 8'h83);
    wr(ulc_pkg::ADDR_DATA, 8'h5a);
    wr(ulc_pkg::ADDR_IER, 8'ha5);
    rd(ulc_pkg::ADDR_DATA, 8'hff, 8'h5a);
    rd(ulc_pkg::ADDR_IER, 8'hff, 8'ha5);
    wr(ulc_pkg::ADDR_DATA, 8'h01);
    wr(ulc_pkg::ADDR_IER, 8'h00);
    wr(ulc_pkg::ADDR_LCR, 8'h03);
    rd(ulc_pkg::ADDR_IER, 8'hff, 8'h00);
    modem <= 4'($random(seed));
    wr(ulc_pkg::ADDR_MCR, 8'h03);
    rd(ulc_pkg::ADDR_MSR, 8'hff, {~modem, 4'h0});
    @(negedge clk);
    `CHK({dtr_n, rts_n, so}, 3'b001)
    @(posedge clk);
    // each length, with no, even, odd and space parity, both ways
    for (int i = 0; i < 4; i++) begin
      lcr = {2'b00, i == 3, i[0], i != 0, i[1], i[1:0]};
      nbits <= 4'(5 + i);
      pen <= lcr[3];
      d = 8'($random(seed)) >> (3 - i);
      p = lcr[5] ? ~lcr[4] : ^d ^ ~lcr[4];
      wr(ulc_pkg::ADDR_LCR, lcr);
      tq.push_back({lcr[3] & p, d});
      tq.push_back({lcr[3] & (p ^ ~lcr[5]), d ^ 8'h01});
      wr(ulc_pkg::ADDR_DATA, d);
      wr(ulc_pkg::ADDR_DATA, d ^ 8'h01);
      rd(ulc_pkg::ADDR_LSR, 8'h60, 8'h00);
      wait_tx(gots + 2);
      repeat (40) @(posedge clk);
      rd(ulc_pkg::ADDR_LSR, 8'h60, 8'h60);
      remote.send(d, 5 + i, lcr[3], p, 1'b1, 16);
      rd(ulc_pkg::ADDR_LSR, 8'h1f, 8'h01);
      rd(ulc_pkg::ADDR_DATA, 8'hff, d);
      rd(ulc_pkg::ADDR_LSR, 8'h01, 8'h00);
    end
    // Receive errors, each cleared by a status read
    wr(ulc_pkg::ADDR_LCR, 8'h1b);
    d = 8'($random(seed));
    remote.send(d, 8, 1'b1, ~^d, 1'b1, 16);
    rd(ulc_pkg::ADDR_LSR, 8'h05, 8'h05);
    rd(ulc_pkg::ADDR_LSR, 8'h04, 8'h00);
    rd(ulc_pkg::ADDR_DATA, 8'hff, d);
    remote.send(d, 8, 1'b1, ^d, 1'b0, 12);
    rd(ulc_pkg::ADDR_LSR, 8'h09, 8'h09);
    rd(ulc_pkg::ADDR_LSR, 8'h08, 8'h00);
    rd(ulc_pkg::ADDR_DATA, 8'hff, d);
    remote.send(8'h00, 8, 1'b1, 1'b0, 1'b0, 16);
    rd(ulc_pkg::ADDR_LSR, 8'h11, 8'h11);
    rd(ulc_pkg::ADDR_LSR, 8'h10, 8'h00);
    rd(ulc_pkg::ADDR_DATA, 8'hff, 8'h00);
    remote.send(d, 8, 1'b1, ^d, 1'b1, 16);
    remote.send(~d, 8, 1'b1, ^d, 1'b1, 16);
    rd(ulc_pkg::ADDR_LSR, 8'h03, 8'h03);
    rd(ulc_pkg::ADDR_LSR, 8'h02, 8'h00);
    rd(ulc_pkg::ADDR_DATA, 8'hff, ~d);
    // error flag while a bad entry waits in the FIFO
    wr(ulc_pkg::ADDR_FIFO, 8'h01);
    remote.send(d, 8, 1'b1, ~^d, 1'b1, 16);
    rd(ulc_pkg::ADDR_LSR, 8'h84, 8'h84);
    rd(ulc_pkg::ADDR_DATA, 8'hff, d);
    rd(ulc_pkg::ADDR_LSR, 8'h81, 8'h80);
    rd(ulc_pkg::ADDR_LSR, 8'h80, 8'h00);
    wr(ulc_pkg::ADDR_FIFO, 8'h00);
    // Diagnostic loopback while the remote end also talks
    wr(ulc_pkg::ADDR_LCR, 8'h03);
    wr(ulc_pkg::ADDR_MCR, 8'h1f);
    @(negedge clk);
    lb <= 1'b1;
    `CHK({dtr_n, rts_n}, 2'b11)
    @(posedge clk);
    rd(ulc_pkg::ADDR_MSR, 8'hff, 8'hf0);
    wr(ulc_pkg::ADDR_MCR, 8'h15);
    rd(ulc_pkg::ADDR_MSR, 8'hff, 8'h60);
    d = 8'($random(seed));
    fork
      remote.send(~d, 8, 1'b0, 1'b0, 1'b1, 16);
      wr(ulc_pkg::ADDR_DATA, d);
    join
    rd(ulc_pkg::ADDR_LSR, 8'h03, 8'h01);
    rd(ulc_pkg::ADDR_DATA, 8'hff, d);
    wr(ulc_pkg::ADDR_MCR, 8'h00);
    lb <= 1'b0;
    // Holding-empty interrupt needs both enables
    wr(ulc_pkg::ADDR_IER, 8'h02);
    @(negedge clk);
    `CHK(irq, 1'b0)
    @(posedge clk);
    wr(ulc_pkg::ADDR_MCR, 8'h08);
    @(negedge clk);
    `CHK(irq, 1'b1)
    @(posedge clk);
    wr(ulc_pkg::ADDR_IER, 8'h00);
    @(negedge clk);
    `CHK(irq, 1'b0)
    @(posedge clk);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : ulc_uart_tb
